// [rtl/pmc_pkg.sv]
// Package of constants and types for the power mode control block
package pmc_pkg;
   localparam logic [7:0] PMC_POWER_CONTROL_ADDR = 8'h87;
   localparam logic [7:0] PMC_OSC_CONTROL_ADDR   = 8'hB2;
   localparam logic [7:0] PMC_POWER_CONTROL_RST  = 8'h00;
   localparam logic [7:0] PMC_OSC_CONTROL_RST    = 8'h80;
   localparam int         PMC_SUSPEND_BIT        = 5;
   localparam int         PMC_STOP_BIT           = 1;
   localparam int         PMC_IDLE_BIT           = 0;
   localparam int         PMC_FLAGS_LSB          = 2;
   localparam int         PMC_FLAGS_MSB          = 7;
   localparam logic [3:0] PMC_MAX_INSTR_CYCLES   = 4'h8;
   localparam logic [3:0] PMC_OSC_RESTART_CYCLES = 4'h2;
   localparam logic [15:0] PMC_RESET_VECTOR      = 16'h0000;

   typedef enum logic [3:0] {
      PMC_RUN     = 4'h1,
      PMC_IDLE    = 4'h2,
      PMC_STOP    = 4'h4,
      PMC_SUSPEND = 4'h8
   } pmc_mode_t;
endpackage

// [rtl/pmc_instr_limit.sv]
// Watch on instruction length, flags any instruction over the cycle limit
module pmc_instr_limit (
   input  wire logic clk_i,        // System clock
   input  wire logic rst_n_i,      // Async reset, active low
   input  wire logic run_i,        // Processor clock enabled
   input  wire logic instr_done_i, // Instruction completes this cycle
   output logic      overrun_o     // Sticky: instruction ran too long
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       overrun;
   } pmc_lim_state_t;

   pmc_lim_state_t s_q, s_d;

   // Count cycles of the current instruction
   always_comb begin
      s_d = s_q;
      if (run_i) begin
         if (instr_done_i) begin
            s_d.cnt = 4'h0;
         end else if (s_q.cnt != 4'hF) begin
            s_d.cnt = s_q.cnt + 4'h1;
         end
         if (!instr_done_i &&
             s_q.cnt >= pmc_pkg::PMC_MAX_INSTR_CYCLES - 4'h1) begin
            s_d.overrun = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign overrun_o = s_q.overrun;
endmodule

// [rtl/pmc_osc_ctrl.sv]
// Oscillator enable control: halts on suspend, restarts on resume or reset
module pmc_osc_ctrl (
   input  wire logic clk_i,         // System clock
   input  wire logic rst_n_i,       // Async reset, active low
   input  wire logic halt_i,        // Suspend or stop requested, pulse
   input  wire logic wake_i,        // USB resume detected, pulse
   output logic      osc_en_o,      // High-frequency oscillator enable
   output logic      osc_ready_o    // Oscillator running and settled
);
   typedef struct packed {
      logic       en;
      logic [3:0] settle;
   } pmc_osc_state_t;

   pmc_osc_state_t s_q, s_d;

   // Wake beats halt so a resume in the same cycle is never lost
   always_comb begin
      s_d = s_q;
      if (wake_i) begin
         s_d.en     = 1'b1;
         s_d.settle = pmc_pkg::PMC_OSC_RESTART_CYCLES;
      end else if (halt_i) begin
         s_d.en     = 1'b0;
         s_d.settle = 4'h0;
      end else if (s_q.settle != 4'h0) begin
         s_d.settle = s_q.settle - 4'h1;
      end
   end

   // Reset always brings the oscillator back up
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '{en: 1'b1, settle: 4'h0};
      end else begin
         s_q <= s_d;
      end
   end

   assign osc_en_o    = s_q.en;
   assign osc_ready_o = s_q.en && (s_q.settle == 4'h0);
endmodule

// [rtl/pmc_power_mode_control.sv]
// Power mode control: power_control register, idle, stop and suspend
//
// Summary of operation
// - Setting suspend bit stops HF oscillator once writing instruction ends
// - Suspend leaves all registers and memory contents untouched
// - Processor keeps running in suspend from any other clock source
// - USB resume signalling or any reset ends suspend; host drives resume
// - Non-reset wake on HF oscillator continues at next instruction
// - Wake source set to interrupt is serviced right after waking
// - Reset wake runs normal reset sequence, fetching from address 0x0000
// - power_control sits at address 0x87 on every register page
// - Bits 7:2 are six read-write flags with no hardware effect
// - Writing 1 to bit 1 enters stop mode; bit reads 0
// - Writing 1 to bit 0 enters idle mode; bit reads 0
// - Idle gates only the processor clock; peripherals keep clocks
// - Every instruction completes within eight system clock cycles
// - System clock may range from zero up to 48 MHz
// - Instructions match the standard 8-bit set; only timing differs
// - Stop mode ends only by reset, followed by normal reset sequence
// - Enabled interrupt in idle clears idle, resumes, services interrupt
module pmc_power_mode_control (
   input  wire logic       clk_i,          // System clock
   input  wire logic       rst_n_i,        // Async reset, active low
   input  wire logic [7:0] sfr_addr_i,     // Register address
   input  wire logic [7:0] sfr_wdata_i,    // Write data
   input  wire logic       sfr_we_i,       // Write strobe, one cycle
   input  wire logic       sfr_re_i,       // Read strobe, one cycle
   output logic      [7:0] sfr_rdata_o,    // Read data, registered
   output logic            sfr_hit_o,      // Read address decoded here
   input  wire logic       instr_done_i,   // Current instruction completes
   input  wire logic       irq_pending_i,  // Enabled interrupt asserted
   input  wire logic       usb_resume_i,   // Transceiver resume detected
   input  wire logic       resume_irq_en_i,// Resume configured as interrupt
   input  wire logic       hfosc_sel_i,    // HF oscillator is system clock
   output logic            cpu_clk_en_o,   // Processor clock enable
   output logic            periph_clk_en_o,// Timers, irq, serial clocks on
   output logic            hfosc_en_o,     // HF oscillator enable
   output logic            hfosc_ready_o,  // HF oscillator settled
   output logic            wake_irq_o,     // Resume interrupt request, pulse
   output logic      [3:0] mode_o,         // Current mode, one-hot
   output logic     [15:0] reset_vector_o, // First fetch address
   output logic            overrun_o       // Instruction exceeded limit
);
   typedef struct packed {
      logic [5:0]          flags;
      logic [7:0]          osc_ctl;
      pmc_pkg::pmc_mode_t  mode;
      logic                idle_arm;
      logic                stop_arm;
      logic                susp_arm;
      logic [7:0]          rdata;
      logic                hit;
      logic                wake_irq;
   } pmc_state_t;

   pmc_state_t s_q, s_d;
   logic       pc_wr;
   logic       osc_wr;
   logic       halt_pulse;
   logic       wake_pulse;
   logic       pc_sel;
   logic       osc_sel;

   // Address matches shared by the write and read paths
   assign pc_sel  = (sfr_addr_i == pmc_pkg::PMC_POWER_CONTROL_ADDR);
   assign osc_sel = (sfr_addr_i == pmc_pkg::PMC_OSC_CONTROL_ADDR);

   // Decode ignores page selection
   always_comb begin
      pc_wr  = 1'b0;
      osc_wr = 1'b0;
      if (sfr_we_i && pc_sel) begin
         pc_wr = 1'b1;
      end else if (sfr_we_i && osc_sel) begin
         osc_wr = 1'b1;
      end
   end

   // Mode sequencing; arms wait for the writing instruction to finish
   always_comb begin
      s_d          = s_q;
      s_d.wake_irq = 1'b0;
      s_d.hit      = 1'b0;
      halt_pulse   = 1'b0;
      wake_pulse   = 1'b0;
      if (pc_wr) begin
         s_d.flags = sfr_wdata_i[pmc_pkg::PMC_FLAGS_MSB:
                                 pmc_pkg::PMC_FLAGS_LSB];
         if (sfr_wdata_i[pmc_pkg::PMC_STOP_BIT])
            s_d.stop_arm = 1'b1;
         if (sfr_wdata_i[pmc_pkg::PMC_IDLE_BIT])
            s_d.idle_arm = 1'b1;
      end
      if (osc_wr) begin
         s_d.osc_ctl = sfr_wdata_i;
         s_d.osc_ctl[pmc_pkg::PMC_SUSPEND_BIT] = 1'b0;
         if (sfr_wdata_i[pmc_pkg::PMC_SUSPEND_BIT])
            s_d.susp_arm = 1'b1;
      end
      case (s_q.mode)
         pmc_pkg::PMC_RUN: begin
            if (instr_done_i && s_q.stop_arm) begin
               s_d.mode     = pmc_pkg::PMC_STOP;
               s_d.stop_arm = 1'b0;
               s_d.idle_arm = 1'b0;
               halt_pulse   = 1'b1;
            end else if (instr_done_i && s_q.idle_arm) begin
               s_d.mode     = pmc_pkg::PMC_IDLE;
               s_d.idle_arm = 1'b0;
            end else if (instr_done_i && s_q.susp_arm) begin
               s_d.mode     = pmc_pkg::PMC_SUSPEND;
               s_d.susp_arm = 1'b0;
               halt_pulse   = 1'b1;
            end
         end
         pmc_pkg::PMC_IDLE: begin
            if (irq_pending_i)
               s_d.mode = pmc_pkg::PMC_RUN;
         end
         pmc_pkg::PMC_STOP: begin
            s_d.mode = pmc_pkg::PMC_STOP;
         end
         pmc_pkg::PMC_SUSPEND: begin
            if (usb_resume_i) begin
               s_d.mode     = pmc_pkg::PMC_RUN;
               wake_pulse   = 1'b1;
               s_d.wake_irq = resume_irq_en_i;
            end
         end
         default: begin
            s_d.mode = pmc_pkg::PMC_RUN;
         end
      endcase
      // Read path; control bits read as zero
      if (sfr_re_i && pc_sel) begin
         s_d.rdata = {s_d.flags, 2'b00};
         s_d.hit   = 1'b1;
      end else if (sfr_re_i && osc_sel) begin
         s_d.rdata = s_q.osc_ctl;
         s_d.hit   = 1'b1;
      end
   end

   // Reset restores every mode to run and every register to its reset value
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '{flags:    6'h00,
                  osc_ctl:  pmc_pkg::PMC_OSC_CONTROL_RST,
                  mode:     pmc_pkg::PMC_RUN,
                  idle_arm: 1'b0,
                  stop_arm: 1'b0,
                  susp_arm: 1'b0,
                  rdata:    8'h00,
                  hit:      1'b0,
                  wake_irq: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   pmc_osc_ctrl u_osc (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .halt_i      (halt_pulse),
      .wake_i      (wake_pulse),
      .osc_en_o    (hfosc_en_o),
      .osc_ready_o (hfosc_ready_o)
   );

   pmc_instr_limit u_lim (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .run_i        (cpu_clk_en_o),
      .instr_done_i (instr_done_i),
      .overrun_o    (overrun_o)
   );

   // Suspend keeps the processor clocked on another source
   assign cpu_clk_en_o = (s_q.mode == pmc_pkg::PMC_RUN) ||
                         (s_q.mode == pmc_pkg::PMC_SUSPEND &&
                          !hfosc_sel_i);
   assign periph_clk_en_o = (s_q.mode != pmc_pkg::PMC_STOP);
   assign wake_irq_o      = s_q.wake_irq;
   assign mode_o          = s_q.mode;
   assign sfr_rdata_o     = s_q.rdata;
   assign sfr_hit_o       = s_q.hit;
   assign reset_vector_o  = pmc_pkg::PMC_RESET_VECTOR;
   // Clock range and instruction set conformance live in the core.
endmodule

// [test/pmc_usb_host.sv]
// Model of a USB host that drives resume signalling on request
module pmc_usb_host #(
   parameter int DELAY = 1, // Cycles before resume starts
   parameter int LEN   = 4  // Cycles of resume signalling
) (
   input  wire logic clk_i,           // System clock
   input  wire logic go_i,            // Start resume signalling
   output logic      resume_o = 1'b0  // Resume seen on the data lines
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // Resume held for a fixed time, then the lines go back to idle
   always @(posedge clk_i) begin
      if (go_i) cnt <= DELAY + LEN;
      else if (cnt > 0) cnt <= cnt - 1;
      resume_o <= (cnt > 0) && (cnt <= LEN);
   end
endmodule

// [test/pmc_power_mode_control_monitor.sv]
// Checker of register and mode behaviour at the block's ports
module pmc_power_mode_control_monitor (
   input wire logic       clk_i,           // System clock
   input wire logic       rst_n_i,         // Async reset, active low
   input wire logic [7:0] sfr_addr_i,      // Register address
   input wire logic       sfr_re_i,        // Read strobe
   input wire logic [7:0] sfr_rdata_o,     // Read data
   input wire logic       sfr_hit_o,       // Read hit
   input wire logic       irq_pending_i,   // Enabled interrupt
   input wire logic       usb_resume_i,    // Resume detected
   input wire logic       resume_irq_en_i, // Resume raises interrupt
   input wire logic       hfosc_sel_i,     // HF oscillator selected
   input wire logic       cpu_clk_en_o,    // Processor clock enable
   input wire logic       periph_clk_en_o, // Peripheral clock enable
   input wire logic       hfosc_en_o,      // HF oscillator enable
   input wire logic       hfosc_ready_o,   // HF oscillator settled
   input wire logic       wake_irq_o,      // Resume interrupt pulse
   input wire logic [3:0] mode_o           // Current mode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Mode select bits never read back as set
   AST_READ_HIT: assert property (sfr_re_i && sfr_addr_i == 8'h87
      |=> sfr_hit_o && sfr_rdata_o[1:0] == 2'h0) else $error("pc read bad");
   AST_UNMAPPED: assert property (sfr_re_i && sfr_addr_i != 8'h87
      && sfr_addr_i != 8'hB2 |=> !sfr_hit_o) else $error("stray hit");
   AST_SUSP_OSC: assert property ($rose(mode_o == 4'h8)
      |-> !hfosc_en_o) else $error("osc runs in suspend");
   AST_SUSP_CPU: assert property (mode_o == 4'h8 && !hfosc_sel_i
      |-> cpu_clk_en_o) else $error("cpu halted in suspend");
   AST_WAKE: assert property (mode_o == 4'h8 && usb_resume_i
      |=> mode_o == 4'h1 && hfosc_en_o) else $error("no wake");
   AST_WAKE_IRQ: assert property (mode_o == 4'h8 && usb_resume_i
      && resume_irq_en_i |=> wake_irq_o ##1 !wake_irq_o)
      else $error("wake irq bad");
   AST_OSC_READY: assert property (mode_o == 4'h8 && usb_resume_i
      |-> ##[2:4] hfosc_ready_o) else $error("osc not ready");
   AST_STOP_HOLD: assert property (mode_o == 4'h4
      |=> mode_o == 4'h4 && !periph_clk_en_o) else $error("stop left");
   AST_IDLE_CLK: assert property (mode_o == 4'h2
      |-> !cpu_clk_en_o && periph_clk_en_o) else $error("idle clocks");
   AST_IDLE_WAKE: assert property (mode_o == 4'h2 && irq_pending_i
      |=> mode_o == 4'h1) else $error("idle not left");
endmodule

// [test/pmc_power_mode_control_tb.sv]
// Testbench for the power mode control block
module pmc_power_mode_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
   logic [3:0]  mode;
   logic [15:0] vec;
   logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, done = 1'b0;
   logic irq = 1'b0, irq_en = 1'b1, sel = 1'b0, go = 1'b0, d_en = 1'b1;
   logic resume, hit, cpu_en, per_en, osc_en, rdy, wake, ovr;
   int   n_mismatch = 0, checked = 0, cyc = 0, wakes = 0;

   pmc_power_mode_control dut (
      .clk_i(clk), .rst_n_i(rst_n), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
      .sfr_we_i(we), .sfr_re_i(re), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
      .instr_done_i(done), .irq_pending_i(irq), .usb_resume_i(resume),
      .resume_irq_en_i(irq_en), .hfosc_sel_i(sel), .cpu_clk_en_o(cpu_en),
      .periph_clk_en_o(per_en), .hfosc_en_o(osc_en), .hfosc_ready_o(rdy),
      .wake_irq_o(wake), .mode_o(mode), .reset_vector_o(vec),
      .overrun_o(ovr));
   pmc_usb_host host (.clk_i(clk), .go_i(go), .resume_o(resume));

   always #20 clk = ~clk;
   // Instruction ends every fourth cycle, well inside the length limit
   always @(negedge clk) done <= d_en && cyc[1:0] == 2'h0;
   // Cycle count, wake pulse count and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wake === 1'b1) wakes <= wakes + 1;
      if (cyc == 1000) begin
         n_mismatch = n_mismatch + 1;
         complete_run();
      end
   end

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      we = 1'b1;
      @(negedge clk);
      we = 1'b0;
   endtask
   // Unmapped reads leave the data alone, so expect the last value
   task automatic rd(logic [7:0] a, logic [7:0] exp, logic exp_hit);
      @(negedge clk);
      addr = a;
      re = 1'b1;
      @(negedge clk);
      re = 1'b0;
      chk("rdata", {8'h00, exp}, {8'h00, rdata});
      chk("hit", {15'h0, exp_hit}, {15'h0, hit});
   endtask
   task automatic wait_n(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      wait_n(4);
      rst_n = 1'b1;
      rd(8'h87, 8'h00, 1'b1);
      rd(8'h55, 8'h00, 1'b0);
      wr(8'h87, 8'hFC);
      rd(8'h87, 8'hFC, 1'b1);
      chk("mode", 16'h1, {12'h0, mode});
      $display("Test flags done");
      wr(8'h87, 8'hA9);
      wait_n(6);
      chk("mode", 16'h2, {12'h0, mode});
      chk("clk en", 16'h1, {14'h0, cpu_en, per_en});
      rd(8'h87, 8'hA8, 1'b1);
      irq = 1'b1;
      wait_n(2);
      irq = 1'b0;
      chk("mode", 16'h1, {12'h0, mode});
      $display("Test idle done");
      wr(8'hB2, 8'hA0);
      wait_n(6);
      chk("mode", 16'h8, {12'h0, mode});
      chk("osc cpu", 16'h1, {14'h0, osc_en, cpu_en});
      rd(8'h87, 8'hA8, 1'b1);
      go = 1'b1;
      wait_n(1);
      go = 1'b0;
      wait_n(8);
      chk("mode", 16'h1, {12'h0, mode});
      chk("osc", 16'h3, {14'h0, osc_en, rdy});
      chk("wakes", 16'h1, wakes[15:0]);
      rd(8'hB2, 8'h80, 1'b1);
      // Suspend on the HF source stops the processor; no wake interrupt
      sel = 1'b1;
      irq_en = 1'b0;
      wr(8'hB2, 8'h20);
      wait_n(6);
      chk("susp cpu", 16'h10, {11'h0, mode, cpu_en});
      go = 1'b1;
      wait_n(1);
      go = 1'b0;
      wait_n(8);
      chk("wake cpu", 16'h3, {14'h0, mode[0], cpu_en});
      chk("wakes", 16'h1, wakes[15:0]);
      sel = 1'b0;
      irq_en = 1'b1;
      $display("Test suspend done");
      d_en = 1'b0;
      wait_n(12);
      chk("overrun", 16'h1, {15'h0, ovr});
      d_en = 1'b1;
      wr(8'h87, 8'h02);
      wait_n(6);
      irq = 1'b1;
      go = 1'b1;
      wait_n(1);
      go = 1'b0;
      wait_n(8);
      irq = 1'b0;
      chk("mode", 16'h4, {12'h0, mode});
      chk("periph", 16'h0, {15'h0, per_en});
      rst_n = 1'b0;
      wait_n(2);
      rst_n = 1'b1;
      chk("mode", 16'h1, {12'h0, mode});
      chk("vector", 16'h0000, vec);
      rd(8'h87, 8'h00, 1'b1);
      $display("Test stop done");
      complete_run();
   end
endmodule

bind pmc_power_mode_control pmc_power_mode_control_monitor u_mon (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
   .sfr_re_i(sfr_re_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
   .irq_pending_i(irq_pending_i), .usb_resume_i(usb_resume_i),
   .resume_irq_en_i(resume_irq_en_i), .hfosc_sel_i(hfosc_sel_i),
   .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
   .hfosc_en_o(hfosc_en_o), .hfosc_ready_o(hfosc_ready_o),
   .wake_irq_o(wake_irq_o), .mode_o(mode_o));
